// [logic/dma_mem_dev.sv]
`timescale 1ns/100ps
module dma_mem_dev (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Execution unit link
    dma_link_if.dev link,
    // Program store write port
    output logic flash_wr_strobe,
    output logic [15:0] flash_wr_addr,
    output logic [7:0] flash_wr_data,
    // Pointer observation
    output logic [15:0] external_data_pointer,
    output logic [7:0] stack_top_pointer
);

    logic [7:0] sp_r;
    logic [7:0] dpl_r;
    logic [7:0] dph_r;
    logic [7:0] psw_r;
    logic [7:0] xpage_r;
    logic [1:0] program_store_control_r;
    dma_pkg::dma_key_t key_r;
    logic [7:0] iram [dma_pkg::IRAM_DEPTH];
    logic [7:0] external_data_ram [dma_pkg::EXTERNAL_DATA_RAM_DEPTH];
    logic resp_valid_r;
    logic [7:0] resp_rdata_r;
    logic flash_strobe_r;
    logic [15:0] flash_addr_r;
    logic [7:0] flash_data_r;

    logic [7:0] iram_idx;
    logic iram_we;
    logic [7:0] iram_wval;
    logic [7:0] sfr_idx;
    logic sfr_we;
    logic [7:0] sfr_wval;
    logic [7:0] sfr_rval;
    logic [15:0] xaddr;
    logic external_data_ram_we;
    logic flash_hit;
    logic move_external_instr_wr_enabled;
    logic sp_step_en;
    logic [7:0] sp_step;
    logic [7:0] rdata_nxt;
    logic [7:0] index_ptr;

    // Bank register location for register number reg_no in the active bank.
    function automatic logic [7:0] bank_index(input logic [7:0] program_status_word, input logic [2:0] reg_no);
        bank_index = {3'h0, program_status_word[dma_pkg::PSW_BANK_HI_BIT], program_status_word[dma_pkg::PSW_BANK_LO_BIT],
                      reg_no};
    endfunction

    function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] pos,
                                           input logic val);
        logic [7:0] r;
        r = b;
        r[pos] = val;
        put_bit = r;
    endfunction

    assign index_ptr = iram[bank_index(psw_r, {2'h0, link.req_addr[0]})];

    assign sfr_idx = (link.req_op == dma_pkg::OP_BIT) ? {link.req_addr[7:3], 3'h0}
                                                       : link.req_addr[7:0];

    assign xaddr = (link.req_op == dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER) ? {dph_r, dpl_r}
                                                           : {xpage_r, index_ptr};

    assign move_external_instr_wr_enabled = program_store_control_r[dma_pkg::PROGRAM_STORE_CONTROL_WE_BIT];

    always_comb begin
        case (sfr_idx)
            dma_pkg::SFR_SP_ADDR: sfr_rval = sp_r;
            dma_pkg::SFR_DPL_ADDR: sfr_rval = dpl_r;
            dma_pkg::SFR_DPH_ADDR: sfr_rval = dph_r;
            dma_pkg::SFR_PSW_ADDR: sfr_rval = psw_r;
            dma_pkg::SFR_XPAGE_ADDR: sfr_rval = xpage_r;
            dma_pkg::SFR_PROGRAM_STORE_CONTROL_ADDR: sfr_rval = {6'h00, program_store_control_r};
            dma_pkg::SFR_FLASH_KEY_REGISTER_ADDR: sfr_rval = {6'h00, key_r};
            default: sfr_rval = 8'h00;
        endcase
    end

    always_comb begin
        iram_idx = link.req_addr[7:0];
        iram_we = 1'b0;
        iram_wval = link.req_wdata;
        sfr_we = 1'b0;
        sfr_wval = link.req_wdata;
        external_data_ram_we = 1'b0;
        flash_hit = 1'b0;
        sp_step_en = 1'b0;
        sp_step = sp_r;
        rdata_nxt = 8'h00;
        if (link.req_valid) begin
            case (link.req_op)
                dma_pkg::OP_DIRECT: begin
                    if (link.req_addr[dma_pkg::UPPER_SPACE_BIT]) begin
                        sfr_we = link.req_write;
                        rdata_nxt = sfr_rval;
                    end else begin
                        iram_we = link.req_write;
                        rdata_nxt = iram[iram_idx];
                    end
                end
                dma_pkg::OP_REG: begin
                    iram_idx = bank_index(psw_r, link.req_addr[2:0]);
                    iram_we = link.req_write;
                    rdata_nxt = iram[iram_idx];
                end
                dma_pkg::OP_INDIRECT: begin
                    iram_idx = index_ptr;
                    iram_we = link.req_write;
                    rdata_nxt = iram[iram_idx];
                end
                dma_pkg::OP_BIT: begin
                    if (link.req_addr[dma_pkg::UPPER_SPACE_BIT]) begin
                        sfr_we = link.req_write;
                        sfr_wval = put_bit(sfr_rval, link.req_addr[2:0], link.req_wdata[0]);
                        rdata_nxt = {7'h00, sfr_rval[link.req_addr[2:0]]};
                    end else begin
                        iram_idx = dma_pkg::BIT_AREA_BASE + {4'h0, link.req_addr[6:3]};
                        iram_we = link.req_write;
                        iram_wval = put_bit(iram[iram_idx], link.req_addr[2:0],
                                            link.req_wdata[0]);
                        rdata_nxt = {7'h00, iram[iram_idx][link.req_addr[2:0]]};
                    end
                end
                dma_pkg::OP_PUSH: begin
                    sp_step = sp_r + 8'h01;
                    sp_step_en = 1'b1;
                    iram_idx = sp_step;
                    iram_we = 1'b1;
                end
                dma_pkg::OP_POP: begin
                    iram_idx = sp_r;
                    rdata_nxt = iram[iram_idx];
                    sp_step = sp_r - 8'h01;
                    sp_step_en = 1'b1;
                end
                default: begin
                    rdata_nxt = external_data_ram[xaddr[dma_pkg::EXTERNAL_DATA_RAM_AW-1:0]];
                    if (link.req_write) begin
                        if (!move_external_instr_wr_enabled) begin
                            external_data_ram_we = 1'b1;
                        end else if (key_r == dma_pkg::KEY_ARMED &&
                                     !program_store_control_r[dma_pkg::PROGRAM_STORE_CONTROL_EE_BIT]) begin
                            flash_hit = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sp_r <= dma_pkg::SP_RESET;
        end else if (sfr_we && sfr_idx == dma_pkg::SFR_SP_ADDR) begin
            sp_r <= sfr_wval;
        end else if (sp_step_en) begin
            sp_r <= sp_step;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dpl_r <= dma_pkg::DP_RESET;
            dph_r <= dma_pkg::DP_RESET;
        end else if (sfr_we && sfr_idx == dma_pkg::SFR_DPL_ADDR) begin
            dpl_r <= sfr_wval;
        end else if (sfr_we && sfr_idx == dma_pkg::SFR_DPH_ADDR) begin
            dph_r <= sfr_wval;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            psw_r <= dma_pkg::PSW_RESET;
            xpage_r <= dma_pkg::XPAGE_RESET;
            program_store_control_r <= dma_pkg::PROGRAM_STORE_CONTROL_RESET;
        end else if (sfr_we) begin
            if (sfr_idx == dma_pkg::SFR_PSW_ADDR) begin
                psw_r <= sfr_wval;
            end
            if (sfr_idx == dma_pkg::SFR_XPAGE_ADDR) begin
                xpage_r <= sfr_wval;
            end
            if (sfr_idx == dma_pkg::SFR_PROGRAM_STORE_CONTROL_ADDR) begin
                program_store_control_r <= sfr_wval[1:0];
            end
        end
    end

    // Any wrong value or order drops the key, so a runaway store cannot arm it.
    // key sequencing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            key_r <= dma_pkg::KEY_IDLE;
        end else if (sfr_we && sfr_idx == dma_pkg::SFR_FLASH_KEY_REGISTER_ADDR) begin
            if (sfr_wval == dma_pkg::KEY_FIRST && key_r == dma_pkg::KEY_IDLE) begin
                key_r <= dma_pkg::KEY_HALF;
            end else if (sfr_wval == dma_pkg::KEY_SECOND && key_r == dma_pkg::KEY_HALF) begin
                key_r <= dma_pkg::KEY_ARMED;
            end else begin
                key_r <= dma_pkg::KEY_IDLE;
            end
        end else if (link.req_valid && link.req_write && move_external_instr_wr_enabled &&
                     (link.req_op == dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER ||
                      link.req_op == dma_pkg::OP_MOVE_EXTERNAL_INSTR_REG)) begin
            key_r <= dma_pkg::KEY_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (iram_we) begin
            iram[iram_idx] <= iram_wval;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (external_data_ram_we) begin
            external_data_ram[xaddr[dma_pkg::EXTERNAL_DATA_RAM_AW-1:0]] <= link.req_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flash_strobe_r <= 1'b0;
            flash_addr_r <= 16'h0000;
            flash_data_r <= 8'h00;
        end else begin
            flash_strobe_r <= flash_hit;
            if (flash_hit) begin
                flash_addr_r <= xaddr;
                flash_data_r <= link.req_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resp_valid_r <= 1'b0;
            resp_rdata_r <= 8'h00;
        end else begin
            resp_valid_r <= link.req_valid;
            if (link.req_valid) begin
                resp_rdata_r <= rdata_nxt;
            end
        end
    end

    assign link.resp_valid = resp_valid_r;
    assign link.resp_rdata = resp_rdata_r;
    assign flash_wr_strobe = flash_strobe_r;
    assign flash_wr_addr = flash_addr_r;
    assign flash_wr_data = flash_data_r;
    assign external_data_pointer = {dph_r, dpl_r};
    assign stack_top_pointer = sp_r;

endmodule

// [logic/dma_pkg.sv]
package dma_pkg;

    // Special register addresses.
    localparam logic [7:0] SFR_SP_ADDR = 8'h81;
    localparam logic [7:0] SFR_DPL_ADDR = 8'h82;
    localparam logic [7:0] SFR_DPH_ADDR = 8'h83;
    localparam logic [7:0] SFR_PSW_ADDR = 8'hd0;
    localparam logic [7:0] SFR_XPAGE_ADDR = 8'haa;
    localparam logic [7:0] SFR_PROGRAM_STORE_CONTROL_ADDR = 8'h8f;
    localparam logic [7:0] SFR_FLASH_KEY_REGISTER_ADDR = 8'hb7;

    // Reset values.
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] DP_RESET = 8'h00;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [7:0] XPAGE_RESET = 8'h00;
    localparam logic [1:0] PROGRAM_STORE_CONTROL_RESET = 2'h0;

    // Field positions.
    localparam int PSW_BANK_LO_BIT = 3;
    localparam int PSW_BANK_HI_BIT = 4;
    localparam int PROGRAM_STORE_CONTROL_WE_BIT = 0;
    localparam int PROGRAM_STORE_CONTROL_EE_BIT = 1;
    localparam int UPPER_SPACE_BIT = 7;

    // Program store keys and the control values that enable and disable byte writes.
    localparam logic [7:0] KEY_FIRST = 8'ha5;
    localparam logic [7:0] KEY_SECOND = 8'hf1;
    localparam logic [7:0] PROGRAM_STORE_CONTROL_WRITE_ONLY = 8'h01;
    localparam logic [7:0] PROGRAM_STORE_CONTROL_OFF = 8'h00;

    // Memory layout.
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam int IRAM_DEPTH = 256;
    localparam int EXTERNAL_DATA_RAM_DEPTH = 512;
    localparam int EXTERNAL_DATA_RAM_AW = 9;
    localparam logic [2:0] FLASH_LAST_STEP = 3'h6;

    typedef enum logic [2:0] {
        OP_DIRECT = 3'b000,
        OP_INDIRECT = 3'b001,
        OP_BIT = 3'b010,
        OP_PUSH = 3'b011,
        OP_POP = 3'b100,
        OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER = 3'b101,
        OP_MOVE_EXTERNAL_INSTR_REG = 3'b110,
        OP_REG = 3'b111
    } dma_op_t;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_ARMED = 2'b10
    } dma_key_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_SEND = 2'b01,
        HS_WAIT = 2'b10
    } dma_host_state_t;

    typedef struct packed {
        dma_op_t op;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic write;
    } dma_req_t;

endpackage

// [logic/dma_link_if.sv]
`timescale 1ns/100ps
interface dma_link_if;
    logic req_valid;
    dma_pkg::dma_op_t req_op;
    logic [15:0] req_addr;
    logic [7:0] req_wdata;
    logic req_write;
    logic resp_valid;
    logic [7:0] resp_rdata;

    modport dev (
        input req_valid,
        input req_op,
        input req_addr,
        input req_wdata,
        input req_write,
        output resp_valid,
        output resp_rdata
    );

    modport cpu (
        output req_valid,
        output req_op,
        output req_addr,
        output req_wdata,
        output req_write,
        input resp_valid,
        input resp_rdata
    );
endinterface

// [logic/dma_cpu_end.sv]
`timescale 1ns/100ps
module dma_cpu_end (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Command side
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_flash_byte,
    input wire dma_pkg::dma_op_t cmd_op,
    input wire logic [15:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_write,
    // Completion
    output logic done,
    output logic [7:0] done_rdata,
    // Memory block link
    dma_link_if.cpu link
);

    dma_pkg::dma_host_state_t state_r;
    dma_pkg::dma_req_t cmd_q;
    dma_pkg::dma_req_t req_r;
    logic flash_q;
    logic [2:0] step_r;
    logic done_r;
    logic [7:0] done_rdata_r;
    dma_pkg::dma_req_t cmd_in;

    // One program store byte is a fixed sequence of link requests; the page
    // must already be erased, this end does not erase.
    // caller pre-erases page
    function automatic dma_pkg::dma_req_t step_req(input logic flash, input logic [2:0] step,
                                                    input dma_pkg::dma_req_t c);
        dma_pkg::dma_req_t r;
        r.op = dma_pkg::OP_DIRECT;
        r.write = 1'b1;
        r.wdata = dma_pkg::PROGRAM_STORE_CONTROL_OFF;
        r.addr = {8'h00, dma_pkg::SFR_PROGRAM_STORE_CONTROL_ADDR};
        if (!flash) begin
            r = c;
        end else begin
            case (step)
                3'h0: r.wdata = dma_pkg::PROGRAM_STORE_CONTROL_WRITE_ONLY;
                3'h1: begin
                    r.addr = {8'h00, dma_pkg::SFR_DPL_ADDR};
                    r.wdata = c.addr[7:0];
                end
                3'h2: begin
                    r.addr = {8'h00, dma_pkg::SFR_DPH_ADDR};
                    r.wdata = c.addr[15:8];
                end
                3'h3: begin
                    r.addr = {8'h00, dma_pkg::SFR_FLASH_KEY_REGISTER_ADDR};
                    r.wdata = dma_pkg::KEY_FIRST;
                end
                3'h4: begin
                    r.addr = {8'h00, dma_pkg::SFR_FLASH_KEY_REGISTER_ADDR};
                    r.wdata = dma_pkg::KEY_SECOND;
                end
                3'h5: begin
                    r.op = dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER;
                    r.addr = c.addr;
                    r.wdata = c.wdata;
                end
                default: r.wdata = dma_pkg::PROGRAM_STORE_CONTROL_OFF;
            endcase
        end
        step_req = r;
    endfunction

    assign cmd_in = '{op: cmd_op, addr: cmd_addr, wdata: cmd_wdata, write: cmd_write};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= dma_pkg::HS_IDLE;
            step_r <= 3'h0;
            flash_q <= 1'b0;
            cmd_q <= '0;
            req_r <= '0;
        end else begin
            case (state_r)
                dma_pkg::HS_IDLE: begin
                    if (cmd_valid) begin
                        cmd_q <= cmd_in;
                        flash_q <= cmd_flash_byte;
                        step_r <= 3'h0;
                        req_r <= step_req(cmd_flash_byte, 3'h0, cmd_in);
                        state_r <= dma_pkg::HS_SEND;
                    end
                end
                dma_pkg::HS_SEND: state_r <= dma_pkg::HS_WAIT;
                dma_pkg::HS_WAIT: begin
                    if (link.resp_valid) begin
                        if (flash_q && step_r != dma_pkg::FLASH_LAST_STEP) begin
                            step_r <= step_r + 3'h1;
                            req_r <= step_req(1'b1, step_r + 3'h1, cmd_q);
                            state_r <= dma_pkg::HS_SEND;
                        end else begin
                            state_r <= dma_pkg::HS_IDLE;
                        end
                    end
                end
                default: state_r <= dma_pkg::HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done_r <= 1'b0;
            done_rdata_r <= 8'h00;
        end else begin
            done_r <= 1'b0;
            if (state_r == dma_pkg::HS_WAIT && link.resp_valid &&
                !(flash_q && step_r != dma_pkg::FLASH_LAST_STEP)) begin
                done_r <= 1'b1;
                done_rdata_r <= link.resp_rdata;
            end
        end
    end

    assign cmd_ready = (state_r == dma_pkg::HS_IDLE);
    assign link.req_valid = (state_r == dma_pkg::HS_SEND);
    assign link.req_op = req_r.op;
    assign link.req_addr = req_r.addr;
    assign link.req_wdata = req_r.wdata;
    assign link.req_write = req_r.write;
    assign done = done_r;
    assign done_rdata = done_rdata_r;

endmodule

// [testbench/dma_link_asserts.sv]
`timescale 1ns/100ps
module dma_link_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link request and answer
    input wire logic req_valid,
    input wire dma_pkg::dma_op_t req_op,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic req_write,
    input wire logic resp_valid,
    input wire logic [7:0] resp_rdata
);
    dma_pkg::dma_op_t op_r;
    logic [7:0] addr_r;
    logic rd_r;
    logic [7:0] sp_r;

    always_ff @(posedge ref_clk) begin
        if (req_valid) begin
            op_r <= req_op;
            addr_r <= req_addr[7:0];
            rd_r <= !req_write;
        end
    end

    // The expected pointer follows every stack move and every direct write to 81h seen on the link.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sp_r <= 8'h07;
        end else if (req_valid && req_op == dma_pkg::OP_PUSH) begin
            sp_r <= sp_r + 8'h01;
        end else if (req_valid && req_op == dma_pkg::OP_POP) begin
            sp_r <= sp_r - 8'h01;
        end else if (req_valid && req_op == dma_pkg::OP_DIRECT && req_write
                     && req_addr[7:0] == 8'h81) begin
            sp_r <= req_wdata;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_resp_follows_req: assert property (req_valid |=> resp_valid)
        else $error("answer missing after request");
    chk_resp_has_cause: assert property (resp_valid |-> $past(req_valid))
        else $error("answer without request");
    chk_resp_one_pulse: assert property (resp_valid |=> !resp_valid)
        else $error("answer longer than one cycle");
    chk_rdata_holds: assert property (!resp_valid && !$past(rst) |-> $stable(resp_rdata))
        else $error("read data moved between answers");
    chk_req_spacing: assert property (req_valid |=> !req_valid)
        else $error("requests back to back");
    chk_bit_read_width: assert property (resp_valid && op_r == dma_pkg::OP_BIT && rd_r
        |-> resp_rdata[7:1] == 7'h00)
        else $error("bit read returned more than one bit");
    chk_ctrl_read_bits: assert property (resp_valid && op_r == dma_pkg::OP_DIRECT && rd_r
        && addr_r == 8'h8f |-> resp_rdata[7:2] == 6'h00)
        else $error("control register unused bits set");
    chk_stack_ptr_track: assert property (resp_valid && op_r == dma_pkg::OP_DIRECT && rd_r
        && addr_r == 8'h81 |-> resp_rdata == sp_r)
        else $error("stack pointer read differs from expected");
endmodule

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
    logic ref_clk, rst, cmd_valid, cmd_ready, cmd_flash_byte, cmd_write, done;
    dma_pkg::dma_op_t cmd_op;
    logic [15:0] cmd_addr, flash_wr_addr, external_data_pointer;
    logic [7:0] cmd_wdata, done_rdata, flash_wr_data, stack_top_pointer, rd;
    logic flash_wr_strobe;
    logic [23:0] last_flash;
    int strobes = 0;
    int err_total = 0;
    int tests_run = 0;

    dma_link_if link_if ();
    dma_mem_dev dma_mem_dev_inst (.ref_clk(ref_clk), .rst(rst), .link(link_if.dev),
        .flash_wr_strobe(flash_wr_strobe), .flash_wr_addr(flash_wr_addr),
        .flash_wr_data(flash_wr_data), .external_data_pointer(external_data_pointer),
        .stack_top_pointer(stack_top_pointer));
    dma_cpu_end dma_cpu_end_inst (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_flash_byte(cmd_flash_byte), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .done(done),
        .done_rdata(done_rdata), .link(link_if.cpu));
    dma_link_asserts dma_link_asserts_inst (.ref_clk(ref_clk), .rst(rst),
        .req_valid(link_if.req_valid), .req_op(link_if.req_op), .req_addr(link_if.req_addr),
        .req_wdata(link_if.req_wdata), .req_write(link_if.req_write),
        .resp_valid(link_if.resp_valid), .resp_rdata(link_if.resp_rdata));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Strobes are counted at the falling edge, clear of the register update.
    always @(negedge ref_clk) begin
        if (flash_wr_strobe === 1'b1) begin
            strobes++;
            last_flash = {flash_wr_addr, flash_wr_data};
        end
    end

    task automatic end_of_test;
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One command; the cpu end is idle on entry, so the next rising edge takes it.
    task automatic run(input dma_pkg::dma_op_t op, input logic [15:0] a, input logic [7:0] d,
                       input logic w, input logic fl);
        int n;
        n = 0;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_write = w;
        cmd_flash_byte = fl;
        cmd_valid = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        if (done !== 1'b1) begin
            cmp(24'h0, 24'h1);
            end_of_test;
        end
        rd = done_rdata;
    endtask

    task automatic wr(input dma_pkg::dma_op_t op, input logic [7:0] a, input logic [7:0] d);
        run(op, {8'h00, a}, d, 1'b1, 1'b0);
    endtask

    task automatic rq(input dma_pkg::dma_op_t op, input logic [7:0] a);
        run(op, {8'h00, a}, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic set_dp(input logic [15:0] a);
        wr(dma_pkg::OP_DIRECT, 8'h82, a[7:0]);
        wr(dma_pkg::OP_DIRECT, 8'h83, a[15:8]);
    endtask

    task automatic t_reset_and_pointer;
        cmp(stack_top_pointer, 8'h07);
        cmp(external_data_pointer, 16'h0000);
        rq(dma_pkg::OP_DIRECT, 8'h83);
        cmp(rd, 8'h00);
        set_dp(16'h1234);
        cmp(external_data_pointer, 16'h1234);
        rq(dma_pkg::OP_DIRECT, 8'h83);
        cmp(rd, 8'h12);
    endtask

    task automatic t_spaces_and_banks;
        wr(dma_pkg::OP_REG, 8'h00, 8'h81);
        wr(dma_pkg::OP_INDIRECT, 8'h00, 8'h3c);
        rq(dma_pkg::OP_INDIRECT, 8'h00);
        cmp(rd, 8'h3c);
        rq(dma_pkg::OP_DIRECT, 8'h81);
        cmp(rd, 8'h07);
        for (int b = 0; b < 4; b++) begin
            wr(dma_pkg::OP_DIRECT, 8'hd0, 8'(b << 3));
            wr(dma_pkg::OP_REG, 8'h01, 8'(8'h40 + b));
        end
        for (int b = 0; b < 4; b++) begin
            rq(dma_pkg::OP_DIRECT, 8'(b * 8 + 1));
            cmp(rd, 8'(8'h40 + b));
        end
        wr(dma_pkg::OP_INDIRECT, 8'h01, 8'h77);
        rq(dma_pkg::OP_DIRECT, 8'h43);
        cmp(rd, 8'h77);
        wr(dma_pkg::OP_DIRECT, 8'hd0, 8'h00);
    endtask

    task automatic t_bits_and_stack;
        wr(dma_pkg::OP_DIRECT, 8'h22, 8'h00);
        wr(dma_pkg::OP_DIRECT, 8'h2f, 8'h00);
        wr(dma_pkg::OP_BIT, 8'h13, 8'h01);
        wr(dma_pkg::OP_BIT, 8'h7f, 8'h01);
        rq(dma_pkg::OP_DIRECT, 8'h22);
        cmp(rd, 8'h08);
        rq(dma_pkg::OP_DIRECT, 8'h2f);
        cmp(rd, 8'h80);
        rq(dma_pkg::OP_BIT, 8'h12);
        cmp(rd, 8'h00);
        wr(dma_pkg::OP_PUSH, 8'h00, 8'hab);
        cmp(stack_top_pointer, 8'h08);
        rq(dma_pkg::OP_DIRECT, 8'h08);
        cmp(rd, 8'hab);
        wr(dma_pkg::OP_DIRECT, 8'h81, 8'hff);
        wr(dma_pkg::OP_PUSH, 8'h00, 8'hcd);
        rq(dma_pkg::OP_DIRECT, 8'h00);
        cmp(rd, 8'hcd);
        rq(dma_pkg::OP_POP, 8'h00);
        cmp({rd, stack_top_pointer}, 16'hcdff);
    endtask

    task automatic t_external_data_ram;
        set_dp(16'h0200);
        wr(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00, 8'h11);
        set_dp(16'h0000);
        rq(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00);
        cmp(rd, 8'h11);
        wr(dma_pkg::OP_DIRECT, 8'haa, 8'h01);
        wr(dma_pkg::OP_REG, 8'h00, 8'h23);
        wr(dma_pkg::OP_MOVE_EXTERNAL_INSTR_REG, 8'h00, 8'h66);
        set_dp(16'h0123);
        rq(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00);
        cmp(rd, 8'h66);
        cmp(24'(strobes), 24'h000000);
    endtask

    task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
        wr(dma_pkg::OP_DIRECT, 8'hb7, k1);
        wr(dma_pkg::OP_DIRECT, 8'hb7, k2);
    endtask

    task automatic t_flash;
        set_dp(16'h0345);
        wr(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00, 8'h99);
        run(dma_pkg::OP_DIRECT, 16'h0345, 8'h5e, 1'b1, 1'b1);
        cmp(last_flash, 24'h03455e);
        cmp(24'(strobes), 24'h000001);
        rq(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00);
        cmp(rd, 8'h99);
        wr(dma_pkg::OP_DIRECT, 8'h8f, 8'h01);
        rq(dma_pkg::OP_DIRECT, 8'h8f);
        cmp(rd, 8'h01);
        wr(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00, 8'h42);
        keys(8'hf1, 8'ha5);
        wr(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00, 8'h43);
        keys(8'ha5, 8'hf1);
        wr(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00, 8'h44);
        wr(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00, 8'h45);
        cmp({strobes[7:0], last_flash[7:0]}, 16'h0244);
        rq(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00);
        cmp(rd, 8'h99);
        wr(dma_pkg::OP_DIRECT, 8'h8f, 8'h03);
        keys(8'ha5, 8'hf1);
        wr(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00, 8'h46);
        cmp(24'(strobes), 24'h000002);
        wr(dma_pkg::OP_DIRECT, 8'h8f, 8'h00);
        wr(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00, 8'h47);
        rq(dma_pkg::OP_MOVE_EXTERNAL_INSTR_EXTERNAL_DATA_POINTER, 8'h00);
        cmp({strobes[7:0], rd}, 16'h0247);
    endtask

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_flash_byte = 1'b0;
        cmd_op = dma_pkg::OP_DIRECT;
        cmd_addr = 16'h0000;
        cmd_wdata = 8'h00;
        cmd_write = 1'b0;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        t_reset_and_pointer;
        t_spaces_and_banks;
        t_bits_and_stack;
        t_external_data_ram;
        t_flash;
        end_of_test;
    end
endmodule
